// File: rtl/tcc_pkg.sv
// package for the timer capture/compare block
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package tcc_pkg;
  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [11:0] TCC_CTRL_OFF = 12'h000;
  localparam logic [11:0] TCC_FLAG_OFF = 12'h004;
  localparam logic [11:0] TCC_CNT_OFF = 12'h008;
  localparam logic [11:0] TCC_CAPL_OFF = 12'h00C;
  localparam logic [11:0] TCC_CAPH_OFF = 12'h010;
  localparam logic [11:0] TCC_CMPAL_OFF = 12'h014;
  localparam logic [11:0] TCC_CMPAH_OFF = 12'h018;
  localparam logic [11:0] TCC_CMPBL_OFF = 12'h01C;
  localparam logic [11:0] TCC_CMPBH_OFF = 12'h020;
  localparam logic [11:0] TCC_FORCE_OFF = 12'h024;
  // ---------------------------------------------------------------------------
  // control and flag field positions
  // ---------------------------------------------------------------------------
  localparam int TCC_WGM_LSB = 0;
  localparam int TCC_COMA_LSB = 4;
  localparam int TCC_COMB_LSB = 6;
  localparam int TCC_SRC_BIT = 8;
  localparam int TCC_FILT_BIT = 9;
  localparam int TCC_EDGE_BIT = 10;
  localparam int TCC_IEA_BIT = 11;
  localparam int TCC_IEB_BIT = 12;
  localparam int TCC_CAPF_BIT = 0;
  localparam int TCC_CMPAF_BIT = 1;
  localparam int TCC_CMPBF_BIT = 2;
  // ---------------------------------------------------------------------------
  // reset values, counts and waveform mode codes
  // ---------------------------------------------------------------------------
  localparam logic [15:0] TCC_CTRL_RST = 16'h0000;
  localparam logic [15:0] TCC_CMP_RST = 16'h0000;
  localparam logic [15:0] TCC_MAX = 16'hFFFF;
  localparam int TCC_FILT_SAMPLES = 4;
  localparam logic [3:0] TCC_WGM_CTC_CAP = 4'hC;
  localparam logic [3:0] TCC_WGM_FPWM_CAP = 4'hE;
  localparam logic [3:0] TCC_WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] TCC_WGM_PC_CAP = 4'hA;
  localparam logic [3:0] TCC_WGM_CTC_A = 4'h4;
  // ---------------------------------------------------------------------------
  // carried groups
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] waveform_mode_select;
    logic [1:0] action_a;
    logic [1:0] action_b;
    logic capture_source_select;
    logic capture_filter_enable;
    logic capture_rising;
    logic irq_en_a;
    logic irq_en_b;
  } tcc_ctrl_s;
  typedef struct packed {
    logic capture;
    logic cmp_a;
    logic cmp_b;
  } tcc_irq_s;
endpackage : tcc_pkg

// File: rtl/tcc_timer.sv
// capture/compare units of a 16-bit timer with an APB register slave
`timescale 1ns/1ps
module tcc_timer (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer side
  input wire logic timer_tick,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic irq_ack_capture,
  input wire logic irq_ack_a,
  input wire logic irq_ack_b,
  // outputs
  output logic [1:0] channel_output_state,
  output tcc_pkg::tcc_irq_s irq_req
);
  import tcc_pkg::*;
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  tcc_ctrl_s ctrl;
  logic [15:0] count_register;
  logic [15:0] capture_register;
  logic [15:0] cmp_act [2];
  logic [15:0] cmp_buf [2];
  logic [7:0] temp_latch;
  logic capture_flag;
  logic [1:0] compare_flag;
  logic [1:0] match_pend;
  logic block_next;
  logic [1:0] samp;
  logic [TCC_FILT_SAMPLES-1:0] filt_hist;
  logic filt_out;
  logic edge_prev;
  logic count_down;
  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire hit_ctrl = paddr == TCC_CTRL_OFF;
  wire hit_flag = paddr == TCC_FLAG_OFF;
  wire hit_cnt = paddr == TCC_CNT_OFF;
  wire hit_capl = paddr == TCC_CAPL_OFF;
  wire hit_caph = paddr == TCC_CAPH_OFF;
  wire hit_force = paddr == TCC_FORCE_OFF;
  wire [1:0] hit_cl = {paddr == TCC_CMPBL_OFF, paddr == TCC_CMPAL_OFF};
  wire [1:0] hit_ch = {paddr == TCC_CMPBH_OFF, paddr == TCC_CMPAH_OFF};
  wire mapped = hit_ctrl | hit_flag | hit_cnt | hit_capl | hit_caph | hit_force
    | (|hit_cl) | (|hit_ch);
  wire [3:0] wgm = ctrl.waveform_mode_select;
  wire pwm_mode = !(wgm == 4'h0 || wgm == TCC_WGM_CTC_A || wgm == TCC_WGM_CTC_CAP);
  wire cap_top = wgm == TCC_WGM_CTC_CAP || wgm == TCC_WGM_FPWM_CAP
    || wgm == TCC_WGM_PFC_CAP || wgm == TCC_WGM_PC_CAP;
  wire dual_slope = pwm_mode && (wgm[3:2] == 2'b10 || wgm[3:1] == 3'b000 || wgm == 4'h3
    || wgm == 4'h2 || wgm == 4'h1);
  wire a_top = wgm == TCC_WGM_CTC_A || wgm == 4'hF || wgm == 4'hB || wgm == 4'h9;
  wire [15:0] top_val = a_top ? cmp_act[0] : cap_top ? capture_register : TCC_MAX;
  wire cnt_wr = wr && hit_cnt;
  // ---------------------------------------------------------------------------
  // counter (simplified sequence for the compare units)
  // ---------------------------------------------------------------------------
  wire at_top = count_register == top_val;
  wire at_bot = count_register == 16'h0000;
  wire top_hit = at_top && !block_next;
  logic [15:0] next_count;
  assign next_count = cnt_wr ? pwdata[15:0]
    : !timer_tick ? count_register
    : dual_slope ? (count_down ? count_register - 16'h0001 : count_register + 16'h0001)
    : (top_hit && wgm != 4'h0) ? 16'h0000 : count_register + 16'h0001;
  wire upd_pt = timer_tick && (dual_slope ? at_bot : top_hit);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_register <= 16'h0000;
      count_down <= 1'b0;
    end else begin
      count_register <= next_count;
      if (timer_tick && dual_slope) begin
        if (top_hit) begin
          count_down <= 1'b1;
        end else if (at_bot) begin
          count_down <= 1'b0;
        end
      end
    end
  end
  // ---------------------------------------------------------------------------
  // capture input: sample, filter, edge, source
  // ---------------------------------------------------------------------------
  wire cap_src = ctrl.capture_source_select ? comparator_output : capture_pin;
  wire filt_same = &filt_hist || ~|filt_hist;
  wire det_in = ctrl.capture_filter_enable ? filt_out : samp[1];
  wire cap_edge = (det_in != edge_prev) && (det_in == ctrl.capture_rising) && !cap_top;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp <= 2'b00;
      filt_hist <= '0;
      filt_out <= 1'b0;
      edge_prev <= 1'b0;
    end else begin
      samp <= {samp[0], cap_src};
      filt_hist <= {filt_hist[TCC_FILT_SAMPLES-2:0], samp[1]};
      if (filt_same) begin
        filt_out <= filt_hist[0];
      end
      edge_prev <= det_in;
    end
  end
  // ---------------------------------------------------------------------------
  // capture register and flag
  // ---------------------------------------------------------------------------
  wire cap_wr_ok = wr && cap_top;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_register <= 16'h0000;
      capture_flag <= 1'b0;
    end else begin
      if (cap_edge) begin
        capture_register <= count_register;
      end else if (cap_wr_ok && hit_capl) begin
        capture_register <= {temp_latch, pwdata[7:0]};
      end
      if (cap_edge) begin
        capture_flag <= 1'b1;
      end else if ((wr && hit_flag && pwdata[TCC_CAPF_BIT]) || irq_ack_capture) begin
        capture_flag <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------------------
  // temp latch shared by 16-bit accesses
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_latch <= 8'h00;
    end else if (wr && ((|hit_ch) || hit_caph)) begin
      temp_latch <= pwdata[7:0];
    end else if (rd && hit_capl) begin
      temp_latch <= capture_register[15:8];
    end
  end
  // ---------------------------------------------------------------------------
  // compare channels
  // ---------------------------------------------------------------------------
  wire [1:0] irq_ack = {irq_ack_b, irq_ack_a};
  wire [3:0] act_all = {ctrl.action_b, ctrl.action_a};
  wire [1:0] force_bits = pwdata[1:0];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      wire lw = wr && hit_cl[g];
      wire [15:0] wval = {temp_latch, pwdata[7:0]};
      wire eq = count_register == cmp_act[g];
      wire fire = (timer_tick && match_pend[g]) || (wr && hit_force && force_bits[g] && !pwm_mode);
      wire [1:0] act = act_all[2*g +: 2];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_act[g] <= TCC_CMP_RST;
          cmp_buf[g] <= TCC_CMP_RST;
          match_pend[g] <= 1'b0;
          compare_flag[g] <= 1'b0;
          channel_output_state[g] <= 1'b0;
        end else begin
          if (lw && !pwm_mode) begin
            cmp_act[g] <= wval;
          end else if (pwm_mode && upd_pt) begin
            cmp_act[g] <= cmp_buf[g];
          end
          if (lw) begin
            cmp_buf[g] <= wval;
          end
          if (timer_tick) begin
            match_pend[g] <= eq && !block_next;
          end
          if (timer_tick && match_pend[g]) begin
            compare_flag[g] <= 1'b1;
          end else if ((wr && hit_flag && pwdata[TCC_CMPAF_BIT + g]) || irq_ack[g]) begin
            compare_flag[g] <= 1'b0;
          end
          if (fire) begin
            unique case (act)
              2'b01: channel_output_state[g] <= !channel_output_state[g];
              2'b10: channel_output_state[g] <= 1'b0;
              2'b11: channel_output_state[g] <= 1'b1;
              default: channel_output_state[g] <= channel_output_state[g];
            endcase
          end
        end
      end
    end
  endgenerate
  // ---------------------------------------------------------------------------
  // match blocking and control
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_next <= 1'b0;
      ctrl <= TCC_CTRL_RST[12:0];
    end else begin
      if (cnt_wr) begin
        block_next <= 1'b1;
      end else if (timer_tick) begin
        block_next <= 1'b0;
      end
      if (wr && hit_ctrl) begin
        ctrl <= {pwdata[TCC_WGM_LSB +: 4], pwdata[TCC_COMA_LSB +: 2], pwdata[TCC_COMB_LSB +: 2],
          pwdata[TCC_SRC_BIT], pwdata[TCC_FILT_BIT], pwdata[TCC_EDGE_BIT],
          pwdata[TCC_IEA_BIT], pwdata[TCC_IEB_BIT]};
      end
    end
  end
  // ---------------------------------------------------------------------------
  // read data and outputs
  // ---------------------------------------------------------------------------
  logic [31:0] next_rdata;
  wire [15:0] ctrl_rd = {3'b000, ctrl.irq_en_b, ctrl.irq_en_a, ctrl.capture_rising,
    ctrl.capture_filter_enable, ctrl.capture_source_select, ctrl.action_b, ctrl.action_a,
    ctrl.waveform_mode_select};
  wire [15:0] cmp_rd0 = pwm_mode ? cmp_buf[0] : cmp_act[0];
  wire [15:0] cmp_rd1 = pwm_mode ? cmp_buf[1] : cmp_act[1];
  assign next_rdata = hit_ctrl ? {16'h0000, ctrl_rd}
    : hit_flag ? {29'h0, compare_flag, capture_flag}
    : hit_cnt ? {16'h0000, count_register}
    : hit_capl ? {24'h0, capture_register[7:0]}
    : hit_caph ? {24'h0, temp_latch}
    : hit_cl[0] ? {24'h0, cmp_rd0[7:0]}
    : hit_ch[0] ? {24'h0, cmp_rd0[15:8]}
    : hit_cl[1] ? {24'h0, cmp_rd1[7:0]}
    : hit_ch[1] ? {24'h0, cmp_rd1[15:8]}
    : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_req <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h0;
      irq_req <= '{capture: capture_flag, cmp_a: compare_flag[0] && ctrl.irq_en_a,
        cmp_b: compare_flag[1] && ctrl.irq_en_b};
    end
  end
  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
    cap_edge |=> capture_flag && capture_register == $past(count_register))
    else $error("capture did not copy counter");
  a_block_match: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr ##1 timer_tick |=> !match_pend[0] && !match_pend[1])
    else $error("match not blocked after counter write");
  a_flag_after: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && match_pend[0] |=> compare_flag[0])
    else $error("compare flag not set");
  a_force_noflag: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_force && !compare_flag[0] && !(timer_tick && match_pend[0]) |=> !compare_flag[0])
    else $error("force set compare flag");
  a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !filt_same |=> filt_out == $past(filt_out))
    else $error("filter changed on unequal samples");
  a_cmp_direct: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_cl[0] && !pwm_mode |=> cmp_act[0] == {$past(temp_latch), $past(pwdata[7:0])})
    else $error("direct compare write lost");
  a_cmp_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr && !upd_pt |=> $stable(cmp_buf[0]) && $stable(cmp_act[0]))
    else $error("compare register changed without write");
  a_cap_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_flag && pwdata[0] && !cap_edge |=> !capture_flag)
    else $error("capture flag not cleared");
endmodule : tcc_timer

// File: bench/tcc_tick_src.sv
// prescaled timer clock source on the far side of the block
`timescale 1ns/1ps
module tcc_tick_src #(
  parameter int DIV = 4
) (
  // clock
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  // tick
  output logic timer_tick
);
  logic [7:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      timer_tick <= 1'b0;
    end else begin
      cnt <= (run && cnt != 8'(DIV - 1)) ? cnt + 8'h01 : 8'h00;
      // one pclk wide, system clock keeps running while stopped
      timer_tick <= run && cnt == 8'(DIV - 1);
    end
  end
endmodule : tcc_tick_src

// File: bench/tcc_timer_test.sv
// testbench for the timer capture/compare block
`timescale 1ns/1ps
module tcc_timer_test;
  import tcc_pkg::*;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_tick;
  logic run = 1'b0;
  logic pin = 1'b0;
  logic cmp_out = 1'b0;
  logic ack_c = 1'b0;
  logic ack_a = 1'b0;
  logic ack_b = 1'b0;
  logic [1:0] chan;
  tcc_irq_s irq;
  logic [31:0] rd;
  logic er;
  logic [11:0] rd_offs [6] = '{TCC_CTRL_OFF, TCC_FLAG_OFF, TCC_CMPAL_OFF, TCC_CMPAH_OFF,
    TCC_CMPBL_OFF, TCC_CMPBH_OFF};
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  always #50 pclk = ~pclk;
  tcc_timer u_tcc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_tick(timer_tick), .capture_pin(pin),
    .comparator_output(cmp_out), .irq_ack_capture(ack_c), .irq_ack_a(ack_a),
    .irq_ack_b(ack_b), .channel_output_state(chan), .irq_req(irq));
  tcc_tick_src #(.DIV(4)) u_tcc_tick_src (.pclk(pclk), .presetn(presetn), .run(run),
    .timer_tick(timer_tick));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_clk
  task automatic set_pin(input logic v, input int n);
    pin <= v;
    wait_clk(n);
  endtask : set_pin
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      end_sim();
    end
  end
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    wait_clk(3);
    presetn <= 1'b1;
    wait_clk(1);
    foreach (rd_offs[i]) begin
      apb(1'b0, rd_offs[i], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test reset done");
    apb(1'b1, TCC_CTRL_OFF, 32'h0400);
    apb(1'b1, TCC_FLAG_OFF, 32'h1);
    apb(1'b1, TCC_CNT_OFF, 32'h1234);
    set_pin(1'b1, 12);
    chk({31'h0, irq.capture}, 32'h1);
    apb(1'b0, TCC_CAPL_OFF, 32'h0);
    chk(rd, 32'h34);
    apb(1'b1, TCC_CNT_OFF, 32'h5678);
    apb(1'b0, TCC_CAPH_OFF, 32'h0);
    chk(rd, 32'h12);
    set_pin(1'b0, 8);
    set_pin(1'b1, 12);
    apb(1'b0, TCC_CAPL_OFF, 32'h0);
    chk(rd, 32'h78);
    apb(1'b0, TCC_CAPH_OFF, 32'h0);
    chk(rd, 32'h56);
    ack_c <= 1'b1;
    wait_clk(1);
    ack_c <= 1'b0;
    wait_clk(2);
    chk({31'h0, irq.capture}, 32'h0);
    $display("test capture done");
    apb(1'b1, TCC_CTRL_OFF, 32'h0600);
    set_pin(1'b0, 12);
    apb(1'b1, TCC_FLAG_OFF, 32'h1);
    set_pin(1'b1, 2);
    set_pin(1'b0, 12);
    chk({31'h0, irq.capture}, 32'h0);
    set_pin(1'b1, 4);
    chk({31'h0, irq.capture}, 32'h0);
    wait_clk(10);
    chk({31'h0, irq.capture}, 32'h1);
    $display("test filter done");
    apb(1'b1, TCC_CTRL_OFF, 32'h0500);
    apb(1'b1, TCC_FLAG_OFF, 32'h1);
    set_pin(1'b0, 8);
    set_pin(1'b1, 12);
    chk({31'h0, irq.capture}, 32'h0);
    cmp_out <= 1'b1;
    wait_clk(12);
    chk({31'h0, irq.capture}, 32'h1);
    $display("test source done");
    apb(1'b1, TCC_CMPBH_OFF, 32'hAB);
    apb(1'b1, TCC_CMPBL_OFF, 32'hCD);
    apb(1'b0, TCC_CMPBH_OFF, 32'h0);
    chk(rd, 32'hAB);
    apb(1'b0, TCC_CMPBL_OFF, 32'h0);
    chk(rd, 32'hCD);
    apb(1'b1, TCC_CTRL_OFF, 32'h0810);
    apb(1'b1, TCC_CMPAH_OFF, 32'h00);
    apb(1'b1, TCC_CMPAL_OFF, 32'h08);
    apb(1'b1, TCC_CNT_OFF, 32'h0008);
    run <= 1'b1;
    wait_clk(12);
    run <= 1'b0;
    chk({31'h0, irq.cmp_a}, 32'h0);
    apb(1'b1, TCC_CNT_OFF, 32'h0005);
    run <= 1'b1;
    for (int n = 0; n < 100 && irq.cmp_a !== 1'b1; n++) wait_clk(1);
    run <= 1'b0;
    chk({31'h0, irq.cmp_a}, 32'h1);
    chk({30'h0, chan}, 32'h1);
    ack_a <= 1'b1;
    wait_clk(1);
    ack_a <= 1'b0;
    wait_clk(2);
    chk({31'h0, irq.cmp_a}, 32'h0);
    $display("test compare done");
    apb(1'b0, TCC_CNT_OFF, 32'h0);
    chk(rd, 32'h0000000A);
    apb(1'b1, TCC_CTRL_OFF, 32'h0020);
    apb(1'b1, TCC_FORCE_OFF, 32'h1);
    wait_clk(2);
    chk({30'h0, chan}, 32'h0);
    apb(1'b1, TCC_CTRL_OFF, 32'h0030);
    apb(1'b1, TCC_FORCE_OFF, 32'h1);
    wait_clk(2);
    chk({30'h0, chan}, 32'h1);
    apb(1'b0, TCC_FLAG_OFF, 32'h0);
    chk(rd & 32'h2, 32'h0);
    apb(1'b0, TCC_CNT_OFF, 32'h0);
    chk(rd, 32'h0000000A);
    apb(1'b1, TCC_CTRL_OFF, 32'h0035);
    chk({30'h0, chan}, 32'h1);
    $display("test force done");
    end_sim();
  end
endmodule : tcc_timer_test
